// *** hw/ecc_top.sv ***
// Purpose: edge capture flags and counter compare-set unit
// Assumes: Wishbone classic slave, counters and pins in clk_i domain
// Notes:   counter_step_i marks a counter move caused by an input pulse
//
// Notes on behaviour
// RQ1 - rising port edge sets its capture flag
// RQ2 - capture needs global and port enable
// RQ3 - disabled port ignores edges, flag unchanged
// RQ4 - flag stays set until software clears
// RQ5 - source pulse must outlast filter time
// RQ6 - 32-bit value compared with selected counter
// RQ7 - match sets output bit at once
// RQ8 - match may raise interrupt or start cam
// RQ9 - filter setting 250 ns units, 1..100, reset 1; the unit here is 62 cycles (248 ns)
// RQ10 - output bit holds until separately cleared
// RQ11 - one interrupt pulse per match event
// RQ12 - only pulse-driven counter moves produce matches
// RQ13 - edge beats clear in same cycle
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ecc_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ecc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic                           wb_ack_o,
  output logic [31:0]                    wb_dat_o,
  input  wire logic                      axis_x_input_port_i,
  input  wire logic                      axis_y_input_port_i,
  input  wire logic                      axis_z_input_port_i,
  input  wire logic [31:0]               counter_axis_x_i,
  input  wire logic [31:0]               counter_axis_y_i,
  input  wire logic [31:0]               counter_axis_z_i,
  input  wire logic [2:0]                counter_step_i,
  output logic                           capture_flag_axis_x_o,
  output logic                           capture_flag_axis_y_o,
  output logic                           capture_flag_axis_z_o,
  output logic                           compare_output_o,
  output logic [7:0]                     counter_match_interrupts_o,
  output logic                           cam_start_axis_x_o,
  output logic                           cam_start_axis_y_o,
  output logic                           cam_start_axis_z_o
);
  import ecc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic        ack;      // bus answer
    logic [31:0] dat;      // read data
    logic        gie;      // global_interrupt_enable
    logic [2:0]  cap_en;   // capture enables x, y, z
    logic [2:0]  flag;     // capture flags x, y, z
    logic [6:0]  filt;     // input_filter_setting
    logic [31:0] cmp_val;  // comparison value
    logic        arm;      // compare_set_function on
    logic [1:0]  sel;      // counter select, 3 selects none
    ecc_dest_t   dest;     // match destination
    logic [2:0]  irq_sel;  // which counter interrupt
    logic [1:0]  cam_sel;  // which cam, 3 selects none
    logic        cmp_out;  // compare output bit
    logic [7:0]  irq;      // interrupt pulses
    logic [2:0]  cam;      // cam start pulses
    logic [5:0]  div;      // time unit divider
    logic        tick;     // time unit pulse
  } ecc_top_state_t;

  ecc_top_state_t st;
  ecc_top_state_t next_st;

  logic        bus_req;    // request present
  logic        wr_hit;     // write takes effect this edge
  logic [4:0]  adr;        // byte address
  logic [2:0]  pins;       // raw axis ports
  logic [2:0]  rise;       // filtered rising edges
  logic [2:0]  flag_set;   // qualified edges
  logic [2:0]  flag_clr;   // software clears
  logic        out_clr;    // software clear of compare output
  logic [31:0] sel_val;    // selected counter value
  logic        sel_step;   // selected counter moved by a pulse
  logic        match;      // compare match event

  ////////////////////////////////////////////////////////////////////////
  // input filters

  assign pins = {axis_z_input_port_i, axis_y_input_port_i, axis_x_input_port_i};

  ecc_edge_if edge_lnk[3] ();

  // one filter per axis port
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign edge_lnk[i].tick    = st.tick;
    assign edge_lnk[i].setting = st.filt;
    assign rise[i]             = edge_lnk[i].rise;
    ecc_edge_filter u_filt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (pins[i]),
      .lnk   (edge_lnk[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // helper terms

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_hit  = bus_req & wb_we_i & st.ack;
  assign adr     = {wb_adr_i[4:2], 2'h0};

  // RQ2 both enables gate
  // RQ3 per-port enable
  assign flag_set = rise & st.cap_en & {3{st.gie}};
  assign flag_clr = (wr_hit && adr == OFS_FLAG && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
  assign out_clr  = wr_hit && adr == OFS_STAT && wb_sel_i[0] && wb_dat_i[0];

  // RQ6 counter select
  assign sel_val  = (st.sel == 2'h0) ? counter_axis_x_i :
                    (st.sel == 2'h1) ? counter_axis_y_i : counter_axis_z_i;
  // RQ12 pulse-driven moves only
  assign sel_step = (st.sel == 2'h3) ? 1'b0 : counter_step_i[st.sel];
  assign match    = st.arm & sel_step & (sel_val == st.cmp_val);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st      = st;
    next_st.ack  = 1'b0;
    next_st.irq  = 8'h00;
    next_st.cam  = 3'h0;
    next_st.tick = 1'b0;
    // divider for the filter time unit
    if (st.div == TICK_LAST) begin
      next_st.div  = 6'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 6'h01;
    end
    // answer a fresh request one cycle later, latching read data
    if (bus_req && !st.ack) begin
      next_st.ack = 1'b1;
      if (adr == OFS_CTRL) begin
        next_st.dat = {28'h0, st.cap_en, st.gie};
      end else if (adr == OFS_FLAG) begin
        next_st.dat = {29'h0, st.flag};
      end else if (adr == OFS_FILT) begin
        next_st.dat = {25'h0, st.filt};
      end else if (adr == OFS_CMPV) begin
        next_st.dat = st.cmp_val;
      end else if (adr == OFS_CFG) begin
        next_st.dat = {22'h0, st.cam_sel, st.irq_sel, st.dest, st.sel, st.arm};
      end else if (adr == OFS_STAT) begin
        next_st.dat = {31'h0, st.cmp_out};
      end else begin
        // unmapped: answered, reads zero
        next_st.dat = 32'h0;
      end
    end
    // writes land on the edge that sees ack
    if (wr_hit) begin
      if (adr == OFS_CTRL) begin
        if (wb_sel_i[0]) begin
          next_st.gie    = wb_dat_i[CTRL_GIE];
          next_st.cap_en = wb_dat_i[CTRL_EN_LSB +: 3];
        end
      end else if (adr == OFS_FILT) begin
        // RQ9 out-of-range ignored
        if (wb_sel_i[0] && wb_dat_i[6:0] >= FILT_MIN && wb_dat_i[6:0] <= FILT_MAX
            && wb_dat_i[7] == 1'b0) begin
          next_st.filt = wb_dat_i[6:0];
        end
      end else if (adr == OFS_CMPV) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            next_st.cmp_val[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
      end else if (adr == OFS_CFG) begin
        if (wb_sel_i[0]) begin
          next_st.arm     = wb_dat_i[CFG_ARM];
          next_st.sel     = wb_dat_i[CFG_SEL_LSB +: 2];
          next_st.dest    = ecc_dest_t'(wb_dat_i[CFG_DST_LSB +: 2]);
          next_st.irq_sel = wb_dat_i[CFG_IRQ_LSB +: 3];
        end
        if (wb_sel_i[1]) begin
          next_st.cam_sel = wb_dat_i[CFG_CAM_LSB +: 2];
        end
      end
    end
    // RQ4 sticky flags
    // RQ13 set wins clear
    next_st.flag = (st.flag & ~flag_clr) | flag_set;
    // RQ10 output holds, clear loses
    if (out_clr) begin
      next_st.cmp_out = 1'b0;
    end
    // route a match to its destination
    if (match) begin
      case (st.dest)
        // RQ7 immediate bit set
        ECC_DST_BIT: begin
          next_st.cmp_out = 1'b1;
        end
        // RQ11 single interrupt pulse
        ECC_DST_IRQ: begin
          next_st.irq[st.irq_sel] = 1'b1;
        end
        // RQ8 cam start request
        ECC_DST_CAM: begin
          if (st.cam_sel != 2'h3) begin
            next_st.cam[st.cam_sel] = 1'b1;
          end
        end
        default: begin
          next_st.cmp_out = next_st.cmp_out;
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.filt    <= FILT_RST;
      st.cmp_val <= CMPV_RST;
      st.sel     <= 2'h3;
      st.cam_sel <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign wb_ack_o                   = st.ack;
  assign wb_dat_o                   = st.dat;
  assign capture_flag_axis_x_o      = st.flag[0];
  assign capture_flag_axis_y_o      = st.flag[1];
  assign capture_flag_axis_z_o      = st.flag[2];
  assign compare_output_o           = st.cmp_out;
  assign counter_match_interrupts_o = st.irq;
  assign cam_start_axis_x_o         = st.cam[0];
  assign cam_start_axis_y_o         = st.cam[1];
  assign cam_start_axis_z_o         = st.cam[2];

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_edge_x;
    st.gie && st.cap_en[0] && rise[0];
  endsequence

  sequence s_irq_match;
    match && st.dest == ECC_DST_IRQ;
  endsequence

  AST_RISE_SETS_FLAG: assert property (s_edge_x |=> capture_flag_axis_x_o) // RQ1
    else $error("qualified rising edge did not set flag");

  AST_GATED_CAPTURE: assert property ( // RQ2
    !capture_flag_axis_y_o && !(st.gie && rise[1]) |=> !capture_flag_axis_y_o)
    else $error("flag set without global enable and edge");

  AST_DISABLED_PORT: assert property ( // RQ3
    !st.cap_en[2] && !capture_flag_axis_z_o |=> !capture_flag_axis_z_o)
    else $error("disabled port changed its flag");

  AST_FLAG_STICKY: assert property ( // RQ4
    capture_flag_axis_x_o && !flag_clr[0] |=> capture_flag_axis_x_o)
    else $error("capture flag dropped without clear");

  AST_SET_BEATS_CLEAR: assert property (flag_clr[1] && flag_set[1] |=> st.flag[1]) // RQ13
    else $error("edge lost to clear in same cycle");

  AST_MATCH_SETS_OUT: assert property ( // RQ7
    match && st.dest == ECC_DST_BIT |=> compare_output_o ##1 (compare_output_o || $past(out_clr)))
    else $error("match did not set output bit");

  AST_OUT_HOLDS: assert property (compare_output_o && !out_clr |=> compare_output_o) // RQ10
    else $error("compare output dropped without clear");

  AST_IRQ_ONE_PULSE: assert property ( // RQ11
    s_irq_match ##0 (st.irq_sel == 3'h0) |=> counter_match_interrupts_o[0]
      ##1 (!counter_match_interrupts_o[0] || $past(match)))
    else $error("interrupt not a single pulse");

  AST_NO_STEP_NO_CHANGE: assert property ( // RQ12
    !(|counter_step_i) && !out_clr |=> $stable(compare_output_o) && st.irq == 8'h00)
    else $error("compare result changed without counter pulse");

  AST_CAM_START: assert property ( // RQ8
    match && st.dest == ECC_DST_CAM && st.cam_sel == 2'h1 |=> cam_start_axis_y_o)
    else $error("cam start missing after match");

  AST_FILTER_RANGE: assert property (st.filt >= FILT_MIN && st.filt <= FILT_MAX) // RQ9
    else $error("filter setting out of range");

  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o) // Wishbone ack lasts one cycle
    else $error("ack held longer than one cycle");

endmodule : ecc_top
`default_nettype wire

// *** hw/ecc_pkg.sv ***
// Purpose: shared constants of the edge capture and count compare block
// Assumes: 250 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   byte offsets, field positions, reset values and timing counts
package ecc_pkg;

  // clock and filter time base
  localparam int CLK_MHZ  = 250;                     // system clock rate
  localparam int TICK_NS  = 250;                     // filter time unit
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000; // cycles, rounded down
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);

  // register byte offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;  // enables
  localparam logic [4:0] OFS_FLAG = 5'h04;  // capture flags, write 1 clears
  localparam logic [4:0] OFS_FILT = 5'h08;  // input filter setting
  localparam logic [4:0] OFS_CMPV = 5'h0c;  // comparison value
  localparam logic [4:0] OFS_CFG  = 5'h10;  // compare configuration
  localparam logic [4:0] OFS_STAT = 5'h14;  // compare output, write 1 clears

  // field positions
  localparam int CTRL_GIE    = 0;
  localparam int CTRL_EN_LSB = 1;
  localparam int CFG_ARM     = 0;
  localparam int CFG_SEL_LSB = 1;
  localparam int CFG_DST_LSB = 3;
  localparam int CFG_IRQ_LSB = 5;
  localparam int CFG_CAM_LSB = 8;

  // values after reset and legal range
  localparam logic [6:0]  FILT_RST = 7'h01;
  localparam logic [6:0]  FILT_MIN = 7'h01;
  localparam logic [6:0]  FILT_MAX = 7'h64;
  localparam logic [31:0] CMPV_RST = 32'h0000_0000;

  // where a compare match goes
  typedef enum logic [1:0] {
    ECC_DST_BIT,
    ECC_DST_IRQ,
    ECC_DST_CAM,
    ECC_DST_NONE
  } ecc_dest_t;

endpackage : ecc_pkg

// *** hw/ecc_edge_if.sv ***
// Purpose: link between the control logic and one input edge filter
// Assumes: all signals in the system clock domain
// Notes:   tick is a one-cycle pulse every filter time unit
`timescale 1ns/1ns
`default_nettype none
interface ecc_edge_if;
  logic       tick;     // filter time unit pulse
  logic [6:0] setting;  // filter length in time units
  logic       rise;     // one-cycle pulse on a filtered rising edge
  modport ctl (output tick, output setting, input rise);
  modport flt (input tick, input setting, output rise);
endinterface : ecc_edge_if
`default_nettype wire

// *** hw/ecc_edge_filter.sv ***
// Purpose: debounce one axis input port and flag its rising edges
// Assumes: pin synchronous to clk_i
// Notes:   level changes only after staying put for setting ticks
`timescale 1ns/1ns
`default_nettype none
module ecc_edge_filter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  ecc_edge_if.flt   lnk
);
  import ecc_pkg::*;

  typedef struct packed {
    logic       lvl;   // filtered level
    logic [6:0] cnt;   // ticks the pin has differed
    logic       rise;  // rising edge pulse
  } ecc_flt_state_t;

  ecc_flt_state_t st;
  ecc_flt_state_t next_st;

  assign lnk.rise = st.rise;

  // next state of the filter
  always_comb begin
    next_st      = st;
    next_st.rise = 1'b0;
    if (pin_i == st.lvl) begin
      // pin agrees again: restart the count
      next_st.cnt = 7'h00;
    end else if (lnk.tick) begin
      // RQ5 pulse outlasts filter
      if (st.cnt + 7'h01 >= lnk.setting) begin
        next_st.lvl  = pin_i;
        next_st.cnt  = 7'h00;
        // RQ1 rising edge only
        next_st.rise = pin_i;
      end else begin
        next_st.cnt = st.cnt + 7'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : ecc_edge_filter
`default_nettype wire

// *** testbench/ecc_pulse_src.sv ***
// Purpose: external pulse source driving the three axis input ports
// Assumes: requests arrive synchronous to clk_i
// Notes:   each pulse is held for width_i + 1 cycles, idle level is low
`timescale 1ns/1ns
`default_nettype none
module ecc_pulse_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  go_i,
  input  wire logic [15:0] width_i,
  output logic [2:0]       pin_o
);
  logic [15:0] left [3];  // cycles of the pulse still to hold

  ////////////////////////////////////////////////////////////////////////
  // per-port pulse generator
  // hold beyond filter
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_i) begin
        pin_o[i] <= 1'b0;
        left[i]  <= '0;
      end else if (go_i[i]) begin
        pin_o[i] <= 1'b1;  // clean low to high step
        left[i]  <= width_i;
      end else if (left[i] != 0) begin
        left[i]  <= left[i] - 16'h1;
      end else begin
        pin_o[i] <= 1'b0;  // back to idle low
      end
    end
  end
endmodule : ecc_pulse_src
`default_nettype wire

// *** testbench/test_edge_capture_and_count_compare.sv ***
// Purpose: self-checking bench of the capture flags and compare-set unit
// Assumes: filter set to 2 units, so a pulse of 301 cycles is captured
// Notes:   a small model of flags and match outputs is kept in the bench
`timescale 1ns/1ns
`default_nettype none
module test_edge_capture_and_count_compare;
  import ecc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [4:0]  adr;
  logic [31:0] dat, rdat, q, v;
  logic [2:0]  go, pins, flags, step, cam;
  logic [31:0] cnt [3];   // driven axis counter values
  logic [7:0]  irq;
  logic        cout;
  logic [2:0]  mflag;     // model of capture flags
  int bad_count, comparisons, seed, irq_n[8], cam_n[3], e_irq[8], e_cam[3];

  always #2 clk_i = ~clk_i;  // 250 MHz

  ecc_pulse_src i_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .width_i(16'd300), .pin_o(pins));

  ecc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .axis_x_input_port_i(pins[0]),
    .axis_y_input_port_i(pins[1]), .axis_z_input_port_i(pins[2]),
    .counter_axis_x_i(cnt[0]), .counter_axis_y_i(cnt[1]),
    .counter_axis_z_i(cnt[2]), .counter_step_i(step),
    .capture_flag_axis_x_o(flags[0]), .capture_flag_axis_y_o(flags[1]),
    .capture_flag_axis_z_o(flags[2]), .compare_output_o(cout),
    .counter_match_interrupts_o(irq), .cam_start_axis_x_o(cam[0]),
    .cam_start_axis_y_o(cam[1]), .cam_start_axis_z_o(cam[2]));

  ////////////////////////////////////////////////////////////////////////
  // count one-cycle interrupt and cam pulses
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) if (irq[i] === 1'b1) irq_n[i]++;
    for (int i = 0; i < 3; i++) if (cam[i] === 1'b1) cam_n[i]++;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  // pulse the chosen pins with the given enables, then check the flags
  task automatic capture(input logic [3:0] ctrl, input logic [2:0] p, input logic clr);
    wb(1'b1, OFS_CTRL, {28'h0, ctrl});
    @(posedge clk_i) go <= p;
    @(posedge clk_i) go <= 3'b000;
    repeat (200) @(posedge clk_i);
    mflag = mflag | (p & ctrl[3:1] & {3{ctrl[0]}});
    chk({29'h0, flags}, {29'h0, mflag});
    if (clr) begin
      wb(1'b1, OFS_FLAG, 32'h7);
      mflag = 3'b000;
    end
    repeat (300) @(posedge clk_i);
    wb(1'b0, OFS_FLAG, 32'h0);
    chk(q, {29'h0, mflag});
  endtask : capture

  // land a flag clear on the very edge at which a new edge sets that flag
  // set beats clear
  task automatic collide();
    int n;
    n = 0;
    @(posedge clk_i) go <= 3'b001;
    @(posedge clk_i) go <= 3'b000;
    // probe pulse on x tells the phase of the filter time unit
    while (flags[0] !== 1'b1) begin
      n++;
      if (n > 200) begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge clk_i);
    end
    // tick edges lie two edges before this one, every TICK_CYC cycles
    repeat (TICK_CYC - 4) @(posedge clk_i);
    go <= 3'b010;
    @(posedge clk_i) go <= 3'b000;
    // with two units of filter, y rises on the second tick after its pin
    repeat (TICK_CYC - 1) @(posedge clk_i);
    wb(1'b1, OFS_FLAG, 32'h3);
    mflag = 3'b010;
    @(posedge clk_i);
    chk({29'h0, flags}, {29'h0, mflag});
  endtask : collide

  // present a counter value on the selected axis, with or without a step
  task automatic match(input int s, input logic [31:0] val, input logic stp);
    @(posedge clk_i);
    for (int i = 0; i < 3; i++) cnt[i] <= (i == s) ? val : ~val;
    step <= {3{stp}};
    @(posedge clk_i) step <= 3'b000;
    repeat (3) @(posedge clk_i);
  endtask : match

  function automatic logic [31:0] cfgw(int s, int d, int k, int a);
    return 32'(1) | 32'(s) << CFG_SEL_LSB | 32'(d) << CFG_DST_LSB
      | 32'(k) << CFG_IRQ_LSB | 32'(a) << CFG_CAM_LSB;
  endfunction : cfgw

  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = '0; dat = '0;
    go = '0; step = '0; mflag = '0; seed = 32'h4b33;
    for (int i = 0; i < 3; i++) cnt[i] = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_FILT, 32'h0); chk(q, 32'(FILT_RST));
    wb(1'b1, OFS_FILT, 32'h0);
    wb(1'b1, OFS_FILT, 32'h65);
    wb(1'b0, OFS_FILT, 32'h0); chk(q, 32'h1);
    wb(1'b1, OFS_FILT, 32'h2);
    wb(1'b0, OFS_FILT, 32'h0); chk(q, 32'h2);
    wb(1'b0, 5'h18, 32'h0); chk(q, 32'h0);
    capture(4'he, 3'b111, 1'b0);
    capture(4'h3, 3'b111, 1'b0);
    capture(4'hf, 3'b110, 1'b0);
    capture(4'hf, 3'b001, 1'b1);
    collide();
    v = $random(seed);
    wb(1'b1, OFS_CMPV, v);
    wb(1'b0, OFS_CMPV, 32'h0); chk(q, v);
    for (int s = 0; s < 3; s++) begin
      wb(1'b1, OFS_CFG, cfgw(s, 0, 0, 3));
      match(s, v, 1'b0); chk({31'h0, cout}, 32'h0);
      match(s, v + 32'h1, 1'b1); chk({31'h0, cout}, 32'h0);
      match(s, v, 1'b1); chk({31'h0, cout}, 32'h1);
      match(s, v + 32'h1, 1'b1); chk({31'h0, cout}, 32'h1);
      wb(1'b0, OFS_STAT, 32'h0); chk(q, 32'h1);
      wb(1'b1, OFS_STAT, 32'h1);
      @(posedge clk_i); chk({31'h0, cout}, 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, OFS_CFG, cfgw(0, 1, k, 3));
      match(0, v, 1'b1);
      e_irq[k]++;
    end
    for (int a = 0; a < 4; a++) begin
      wb(1'b1, OFS_CFG, cfgw(1, 2, 0, a));
      match(1, v, 1'b1);
      if (a < 3) e_cam[a]++;
    end
    // destination none: no bit, no interrupt, no cam start
    wb(1'b1, OFS_CFG, cfgw(0, 3, 0, 3));
    match(0, v, 1'b1); chk({31'h0, cout}, 32'h0);
    for (int k = 0; k < 8; k++) chk(32'(irq_n[k]), 32'(e_irq[k]));
    for (int a = 0; a < 3; a++) chk(32'(cam_n[a]), 32'(e_cam[a]));
    tally_and_finish();
  end
endmodule : test_edge_capture_and_count_compare
`default_nettype wire
